/* File: shared/cbo_pkg.sv */
// Package for the branch, bit and indirect-load execution block.
// Assumes a single core clock; shared by the design and its bench.
package cbo_pkg;
   // Operation select codes presented with op_valid
   typedef enum logic [4:0] {
      CBO_OP_BRANCH_OVERFLOW_SET,
      CBO_OP_BRANCH_OVERFLOW_CLEAR,
      CBO_OP_BRANCH_IRQ_ENABLED,
      CBO_OP_BRANCH_IRQ_DISABLED,
      CBO_OP_SET_IO_BIT,
      CBO_OP_CLEAR_IO_BIT,
      CBO_OP_ROTATE_LEFT_CARRY,
      CBO_OP_ROTATE_RIGHT_CARRY,
      CBO_OP_BIT_STORE_TO_TRANSFER,
      CBO_OP_BIT_LOAD_FROM_TRANSFER,
      CBO_OP_SET_CARRY,
      CBO_OP_CLEAR_CARRY,
      CBO_OP_SET_SIGN_FLAG,
      CBO_OP_CLEAR_SIGN_FLAG,
      CBO_OP_SET_OVERFLOW,
      CBO_OP_CLEAR_OVERFLOW,
      CBO_OP_SET_HALF_CARRY,
      CBO_OP_CLEAR_HALF_CARRY,
      CBO_OP_LOAD_POST_INC,
      CBO_OP_LOAD_PRE_DEC,
      CBO_OP_LOAD_DISP
   } cbo_op_e;

   // Status register bit positions
   localparam int unsigned CBO_FLAG_C = 0;
   localparam int unsigned CBO_FLAG_Z = 1;
   localparam int unsigned CBO_FLAG_N = 2;
   localparam int unsigned CBO_FLAG_V = 3;
   localparam int unsigned CBO_FLAG_S = 4;
   localparam int unsigned CBO_FLAG_H = 5;
   localparam int unsigned CBO_FLAG_T = 6;
   localparam int unsigned CBO_FLAG_I = 7;

   localparam int unsigned CBO_DATA_W = 8;
   localparam int unsigned CBO_ADDR_W = 16;
   localparam int unsigned CBO_PC_W   = 16;
   localparam int unsigned CBO_IO_W   = 6;
   localparam int unsigned CBO_REG_W  = 5;

   // Cycle counts per class of operation
   localparam int unsigned CBO_CYC_ONE = 1;
   localparam int unsigned CBO_CYC_TWO = 2;

   localparam logic [7:0]  CBO_STATUS_RST = 8'h00;
   localparam logic [15:0] CBO_PC_RST     = 16'h0000;
   localparam logic [15:0] CBO_PTR_RST    = 16'h0000;
endpackage : cbo_pkg

/* File: verilog/cbo_exec.sv */
// Execution unit for branch-on-flag, I/O bit, rotate, transfer-bit,
// flag set/clear and indirect pointer loads.
// Assumes a sequencer that issues one op when op_ready is high, a data
// memory and I/O space answering reads in the same cycle (combinational).
//
// Notes on behaviour
// RULE1: Overflow branches add offset plus one to PC when V matches; no flags.
// RULE2: Interrupt-state branches add offset plus one when I matches; no flags.
// RULE3: Set-I/O-bit forces chosen bit to one, others kept, two cycles.
// RULE4: Clear-I/O-bit forces chosen bit to zero, others kept, two cycles.
// RULE5: Rotate left through carry; C gets old bit 7; Z,C,N,V in one cycle.
// RULE6: Rotate right through carry; C gets old bit 0; Z,C,N,V in one cycle.
// RULE7: Bit store copies register bit into T only, one cycle.
// RULE8: Bit load copies T into register bit, flags kept, one cycle.
// RULE9: Set and clear carry touch only C, one cycle.
// RULE10: Set and clear sign flag touch only S, one cycle.
// RULE11: Set and clear overflow touch only V, one cycle.
// RULE12: Set and clear half carry touch only H, one cycle.
// RULE13: Post-increment load reads at pointer, then pointer plus one, two cycles.
// RULE14: Pre-decrement load lowers pointer first, reads new address, two cycles.
// RULE15: Displacement load reads pointer plus q, pointer kept, two cycles.
// RULE16: Branch not taken costs one cycle, taken costs two.
// RULE17: Flags not named by an instruction keep their value.
`timescale 1ns/10ps
module cbo_exec
   import cbo_pkg::*;
#(
   parameter int unsigned DISP_W = 6
) (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   // Operation request
   input  wire logic                        op_valid,
   input  wire cbo_pkg::cbo_op_e            op_code,
   input  wire logic [cbo_pkg::CBO_REG_W-1:0] op_reg,
   input  wire logic [2:0]                  op_bit,
   input  wire logic [6:0]                  op_offset,
   input  wire logic [cbo_pkg::CBO_IO_W-1:0]  op_io_addr,
   input  wire logic [1:0]                  op_ptr_sel,
   input  wire logic [DISP_W-1:0]           op_disp,
   input  wire logic [cbo_pkg::CBO_DATA_W-1:0] reg_rdata,
   output logic                             op_ready,
   output logic                             op_done,
   // Program counter and status
   output logic [cbo_pkg::CBO_PC_W-1:0]     pc,
   output logic [7:0]                       status_register,
   // Register file write
   output logic                             reg_we,
   output logic [cbo_pkg::CBO_REG_W-1:0]    reg_waddr,
   output logic [cbo_pkg::CBO_DATA_W-1:0]   reg_wdata,
   // Pointer registers X, Y, Z
   output logic [cbo_pkg::CBO_ADDR_W-1:0]   ptr_x,
   output logic [cbo_pkg::CBO_ADDR_W-1:0]   ptr_y,
   output logic [cbo_pkg::CBO_ADDR_W-1:0]   ptr_z,
   // Data memory read
   output logic                             mem_re,
   output logic [cbo_pkg::CBO_ADDR_W-1:0]   mem_addr,
   input  wire logic [cbo_pkg::CBO_DATA_W-1:0] mem_rdata,
   // I/O space
   output logic                             io_re,
   output logic                             io_we,
   output logic [cbo_pkg::CBO_IO_W-1:0]     io_addr,
   output logic [cbo_pkg::CBO_DATA_W-1:0]   io_wdata,
   input  wire logic [cbo_pkg::CBO_DATA_W-1:0] io_rdata
);
   import cbo_pkg::*;

   // Displacement wider than an address would be cut silently
   if (DISP_W < 1 || DISP_W > CBO_ADDR_W) begin : g_disp_chk
      $error("DISP_W out of range");
   end

   typedef enum logic [1:0] {CBO_ST_IDLE, CBO_ST_SECOND} cbo_state_e;

   cbo_state_e                 state_q;
   cbo_op_e                    op_q;
   logic [CBO_REG_W-1:0]       reg_q;
   logic [2:0]                 bit_q;
   logic [CBO_IO_W-1:0]        io_q;
   logic [CBO_PC_W-1:0]        target_q;
   logic [1:0]                 ptr_q;
   logic [CBO_ADDR_W-1:0]      ptr_cur;
   logic [CBO_ADDR_W-1:0]      ptr_dec;
   logic [CBO_ADDR_W-1:0]      disp_ext;
   logic [CBO_PC_W-1:0]        offs_ext;
   logic                       take;
   logic                       fire;
   logic                       is_load;
   logic                       is_io;
   logic [7:0]                 rot_l;
   logic [7:0]                 rot_r;

   assign fire     = op_valid && op_ready;
   assign disp_ext = CBO_ADDR_W'(op_disp);
   assign offs_ext = {{(CBO_PC_W-7){op_offset[6]}}, op_offset};
   assign is_load  = op_code inside {CBO_OP_LOAD_POST_INC, CBO_OP_LOAD_PRE_DEC,
                                     CBO_OP_LOAD_DISP};
   assign is_io    = op_code inside {CBO_OP_SET_IO_BIT, CBO_OP_CLEAR_IO_BIT};
   assign rot_l    = {reg_rdata[6:0], status_register[CBO_FLAG_C]}; // see RULE5
   assign rot_r    = {status_register[CBO_FLAG_C], reg_rdata[7:1]}; // see RULE6

   always_comb begin
      unique case (op_ptr_sel)
         2'd0:    ptr_cur = ptr_x;
         2'd1:    ptr_cur = ptr_y;
         default: ptr_cur = ptr_z;
      endcase
   end
   assign ptr_dec = ptr_cur - 16'h0001;

   always_comb begin
      unique case (op_code)
         CBO_OP_BRANCH_OVERFLOW_SET:   take = status_register[CBO_FLAG_V];  // see RULE1
         CBO_OP_BRANCH_OVERFLOW_CLEAR: take = !status_register[CBO_FLAG_V]; // see RULE1
         CBO_OP_BRANCH_IRQ_ENABLED:    take = status_register[CBO_FLAG_I];  // see RULE2
         CBO_OP_BRANCH_IRQ_DISABLED:   take = !status_register[CBO_FLAG_I]; // see RULE2
         default:                      take = 1'b0;
      endcase
   end

   // Sequencer: one-cycle ops finish at issue, the rest spend one more
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= CBO_ST_IDLE;
         op_ready <= 1'b1;
         op_done  <= 1'b0;
         op_q     <= CBO_OP_SET_CARRY;
         reg_q    <= '0;
         bit_q    <= '0;
         io_q     <= '0;
         ptr_q    <= '0;
         target_q <= CBO_PC_RST;
      end else begin
         op_done <= 1'b0;
         unique case (state_q)
            CBO_ST_IDLE: begin
               if (fire) begin
                  op_q  <= op_code;
                  reg_q <= op_reg;
                  bit_q <= op_bit;
                  io_q  <= op_io_addr;
                  ptr_q <= op_ptr_sel;
                  target_q <= pc + offs_ext + 16'h0001;
                  if (take || is_load || is_io) begin // see RULE16
                     state_q  <= CBO_ST_SECOND;
                     op_ready <= 1'b0;
                  end else begin
                     op_done <= 1'b1;
                  end
               end
            end
            CBO_ST_SECOND: begin
               state_q  <= CBO_ST_IDLE;
               op_ready <= 1'b1;
               op_done  <= 1'b1;
            end
            default: state_q <= CBO_ST_IDLE;
         endcase
      end
   end

   // Program counter; taken branch commits in the second cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pc <= CBO_PC_RST;
      end else if (state_q == CBO_ST_SECOND && op_q inside {CBO_OP_BRANCH_OVERFLOW_SET,
                   CBO_OP_BRANCH_OVERFLOW_CLEAR, CBO_OP_BRANCH_IRQ_ENABLED,
                   CBO_OP_BRANCH_IRQ_DISABLED}) begin
         pc <= target_q; // see RULE1 see RULE2
      end else if (state_q == CBO_ST_SECOND || fire) begin
         pc <= pc + 16'h0001;
      end
   end

   // Status register: only named flags move, all else holds
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_register <= CBO_STATUS_RST;
      end else if (fire) begin // see RULE17
         unique case (op_code)
            CBO_OP_ROTATE_LEFT_CARRY: begin // see RULE5
               status_register[CBO_FLAG_C] <= reg_rdata[7];
               status_register[CBO_FLAG_Z] <= (rot_l == 8'h00);
               status_register[CBO_FLAG_N] <= rot_l[7];
               status_register[CBO_FLAG_V] <= rot_l[7] ^ reg_rdata[7];
            end
            CBO_OP_ROTATE_RIGHT_CARRY: begin // see RULE6
               status_register[CBO_FLAG_C] <= reg_rdata[0];
               status_register[CBO_FLAG_Z] <= (rot_r == 8'h00);
               status_register[CBO_FLAG_N] <= rot_r[7];
               status_register[CBO_FLAG_V] <= rot_r[7] ^ reg_rdata[0];
            end
            CBO_OP_BIT_STORE_TO_TRANSFER: status_register[CBO_FLAG_T] <= reg_rdata[op_bit]; // see RULE7
            CBO_OP_SET_CARRY:        status_register[CBO_FLAG_C] <= 1'b1; // see RULE9
            CBO_OP_CLEAR_CARRY:      status_register[CBO_FLAG_C] <= 1'b0; // see RULE9
            CBO_OP_SET_SIGN_FLAG:    status_register[CBO_FLAG_S] <= 1'b1; // see RULE10
            CBO_OP_CLEAR_SIGN_FLAG:  status_register[CBO_FLAG_S] <= 1'b0; // see RULE10
            CBO_OP_SET_OVERFLOW:     status_register[CBO_FLAG_V] <= 1'b1; // see RULE11
            CBO_OP_CLEAR_OVERFLOW:   status_register[CBO_FLAG_V] <= 1'b0; // see RULE11
            CBO_OP_SET_HALF_CARRY:   status_register[CBO_FLAG_H] <= 1'b1; // see RULE12
            CBO_OP_CLEAR_HALF_CARRY: status_register[CBO_FLAG_H] <= 1'b0; // see RULE12
            default: ;
         endcase
      end
   end

   // Pointer registers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_x <= CBO_PTR_RST;
         ptr_y <= CBO_PTR_RST;
         ptr_z <= CBO_PTR_RST;
      end else if (fire && op_code inside {CBO_OP_LOAD_POST_INC, CBO_OP_LOAD_PRE_DEC}) begin
         // Address already sampled this cycle, so updating now is safe
         unique case (op_ptr_sel)
            2'd0: ptr_x <= (op_code == CBO_OP_LOAD_PRE_DEC) ? ptr_dec : ptr_cur + 16'h0001;
            2'd1: ptr_y <= (op_code == CBO_OP_LOAD_PRE_DEC) ? ptr_dec : ptr_cur + 16'h0001;
            default: ptr_z <= (op_code == CBO_OP_LOAD_PRE_DEC) ? ptr_dec : ptr_cur + 16'h0001;
         endcase // see RULE13 see RULE14
      end
   end

   // Memory and I/O access; reads sampled by the bus in the cycle after issue
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_re   <= 1'b0;
         mem_addr <= '0;
         io_re    <= 1'b0;
         io_addr  <= '0;
      end else begin
         mem_re <= fire && is_load;
         io_re  <= fire && is_io;
         if (fire && is_load) begin
            unique case (op_code)
               CBO_OP_LOAD_PRE_DEC: mem_addr <= ptr_dec;            // see RULE14
               CBO_OP_LOAD_DISP:    mem_addr <= ptr_cur + disp_ext; // see RULE15
               default:             mem_addr <= ptr_cur;            // see RULE13
            endcase
         end
         if (fire && is_io) begin
            io_addr <= op_io_addr;
         end
      end
   end

   // Write-back to register file and I/O space
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_we    <= 1'b0;
         reg_waddr <= '0;
         reg_wdata <= '0;
         io_we     <= 1'b0;
         io_wdata  <= '0;
      end else begin
         reg_we <= 1'b0;
         io_we  <= 1'b0;
         if (fire) begin
            reg_waddr <= op_reg;
            unique case (op_code)
               CBO_OP_ROTATE_LEFT_CARRY: begin
                  reg_we    <= 1'b1;
                  reg_wdata <= rot_l;
               end
               CBO_OP_ROTATE_RIGHT_CARRY: begin
                  reg_we    <= 1'b1;
                  reg_wdata <= rot_r;
               end
               CBO_OP_BIT_LOAD_FROM_TRANSFER: begin // see RULE8
                  reg_we             <= 1'b1;
                  reg_wdata          <= reg_rdata;
                  reg_wdata[op_bit]  <= status_register[CBO_FLAG_T];
               end
               default: ;
            endcase
         end else if (state_q == CBO_ST_SECOND) begin
            if (op_q inside {CBO_OP_LOAD_POST_INC, CBO_OP_LOAD_PRE_DEC, CBO_OP_LOAD_DISP}) begin
               reg_we    <= 1'b1; // see RULE13 see RULE14 see RULE15
               reg_waddr <= reg_q;
               reg_wdata <= mem_rdata;
            end
            if (op_q inside {CBO_OP_SET_IO_BIT, CBO_OP_CLEAR_IO_BIT}) begin
               io_we            <= 1'b1; // see RULE3 see RULE4
               io_wdata         <= io_rdata;
               io_wdata[bit_q]  <= (op_q == CBO_OP_SET_IO_BIT);
            end
         end
      end
   end

   // Checks
   logic [CBO_PC_W-1:0] offs_ext_q1;
   logic [CBO_PC_W-1:0] offs_ext_q2;
   always_ff @(posedge ref_clk) begin
      offs_ext_q1 <= offs_ext + 16'h0001;
      offs_ext_q2 <= offs_ext_q1;
   end

   sequence s_issue_branch_taken;
      fire && take;
   endsequence

   a_branch_taken_pc: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE1
      s_issue_branch_taken |-> ##2 pc == $past(pc, 2) + offs_ext_q2)
      else $error("taken branch pc wrong");

   a_branch_cycles: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE16
      fire && !take && (op_code inside {CBO_OP_BRANCH_OVERFLOW_SET, CBO_OP_BRANCH_OVERFLOW_CLEAR,
      CBO_OP_BRANCH_IRQ_ENABLED, CBO_OP_BRANCH_IRQ_DISABLED})
      |=> op_done && op_ready)
      else $error("untaken branch not one cycle");

   a_io_set_bit: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE3
      fire && op_code == CBO_OP_SET_IO_BIT |-> ##2 io_we && io_wdata[$past(op_bit, 2)])
      else $error("io bit not set");

   a_io_clear_bit: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE4
      fire && op_code == CBO_OP_CLEAR_IO_BIT |-> ##2 io_we && !io_wdata[$past(op_bit, 2)])
      else $error("io bit not cleared");

   a_rol_carry: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE5
      fire && op_code == CBO_OP_ROTATE_LEFT_CARRY |=> status_register[0] == $past(reg_rdata[7]))
      else $error("rotate left carry wrong");

   a_ror_carry: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE6
      fire && op_code == CBO_OP_ROTATE_RIGHT_CARRY
      |=> status_register[0] == $past(reg_rdata[0]) && reg_wdata[7] == $past(status_register[0]))
      else $error("rotate right wrong");

   a_set_carry_only: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE9
      fire && op_code == CBO_OP_SET_CARRY
      |=> status_register == ($past(status_register) | 8'h01))
      else $error("set carry touched other flags");

   a_load_postinc: assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE13
      fire && op_code == CBO_OP_LOAD_POST_INC && op_ptr_sel == 2'd0
      |=> mem_addr == $past(ptr_x) && ptr_x == $past(ptr_x) + 16'h0001 ##1 reg_we)
      else $error("post-increment load wrong");
endmodule : cbo_exec

/* File: sim/cbo_mem_model.sv */
// Behavioural data memory and I/O register space for the execution block.
// Assumes reads are answered in the same cycle as mem_re or io_re.
`timescale 1ns/10ps
module cbo_mem_model
   import cbo_pkg::*;
(
   // Clock
   input  wire logic                  ref_clk,
   // Data memory read
   input  wire logic                  mem_re,
   input  wire logic [CBO_ADDR_W-1:0] mem_addr,
   output logic      [CBO_DATA_W-1:0] mem_rdata,
   // I/O space
   input  wire logic                  io_re,
   input  wire logic                  io_we,
   input  wire logic [CBO_IO_W-1:0]   io_addr,
   input  wire logic [CBO_DATA_W-1:0] io_wdata,
   output logic      [CBO_DATA_W-1:0] io_rdata
);
   logic [7:0] io_mem [64];
   logic [7:0] mem_last_q;
   logic [7:0] io_last_q;

   // Address-derived content; neighbours differ except across 7FFF/8000 and FFFF/0000
   function automatic logic [7:0] mem_val(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h5A;
   endfunction : mem_val

   initial begin
      for (int i = 0; i < 64; i++) begin
         io_mem[i] = 8'(i) ^ 8'hC3;
      end
   end

   // Released read lines show the inverse of the last byte, never a stale copy
   assign mem_rdata = mem_re ? mem_val(mem_addr) : ~mem_last_q;
   assign io_rdata  = io_re ? io_mem[io_addr] : ~io_last_q;

   always @(posedge ref_clk) begin
      if (mem_re) begin
         mem_last_q <= mem_rdata;
      end
      if (io_re) begin
         io_last_q <= io_rdata;
      end
      if (io_we) begin
         io_mem[io_addr] <= io_wdata;
      end
   end
endmodule : cbo_mem_model

/* File: sim/tb.sv */
// Self-checking bench for the branch, bit and indirect-load block.
// Assumes the memory model answers reads combinationally.
`timescale 1ns/10ps
module tb;
   import cbo_pkg::*;
   logic ref_clk, rst_n, op_valid, op_ready, op_done, reg_we, mem_re, io_re, io_we;
   cbo_op_e     op_code;
   logic [4:0]  op_reg, reg_waddr;
   logic [2:0]  op_bit;
   logic [6:0]  op_offset;
   logic [5:0]  op_io_addr, op_disp, io_addr;
   logic [1:0]  op_ptr_sel;
   logic [7:0]  reg_rdata, status_register, reg_wdata, mem_rdata, io_wdata, io_rdata;
   logic [15:0] pc, ptr_x, ptr_y, ptr_z, mem_addr;
   int fails, cmp_count, ncyc;
   logic [15:0] exp_pc, got_ma;
   logic [7:0]  exp_sr, got_wd, got_iowd, io_exp;
   logic        got_we, got_iowe, got_busy;
   logic [4:0]  got_wa;
   logic [5:0]  got_ia;

   cbo_exec i_cbo_exec (.ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid),
      .op_code(op_code), .op_reg(op_reg), .op_bit(op_bit), .op_offset(op_offset),
      .op_io_addr(op_io_addr), .op_ptr_sel(op_ptr_sel), .op_disp(op_disp),
      .reg_rdata(reg_rdata), .op_ready(op_ready), .op_done(op_done), .pc(pc),
      .status_register(status_register), .reg_we(reg_we), .reg_waddr(reg_waddr),
      .reg_wdata(reg_wdata), .ptr_x(ptr_x), .ptr_y(ptr_y), .ptr_z(ptr_z),
      .mem_re(mem_re), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .io_re(io_re),
      .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));
   cbo_mem_model i_cbo_mem_model (.ref_clk(ref_clk), .mem_re(mem_re),
      .mem_addr(mem_addr), .mem_rdata(mem_rdata), .io_re(io_re), .io_we(io_we),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Issues one op, gathers its port activity, then judges cycles, pc and flags
   task automatic run_op(input cbo_op_e op, input logic [7:0] rd, input logic [2:0] b,
                         input logic [6:0] k, input logic [1:0] ps, input logic [5:0] q,
                         input int exp_n);
      @(posedge ref_clk);
      op_valid <= 1'b1; op_code <= op; reg_rdata <= rd; op_bit <= b;
      op_offset <= k; op_ptr_sel <= ps; op_disp <= q; op_reg <= 5'h03;
      @(posedge ref_clk);
      op_valid <= 1'b0;
      got_we = 1'b0; got_iowe = 1'b0; got_busy = 1'b0; ncyc = 0;
      for (int i = 0; i < 6; i++) begin
         #1;
         ncyc++;
         if (reg_we === 1'b1) begin got_we = 1'b1; got_wd = reg_wdata; got_wa = reg_waddr; end
         if (mem_re === 1'b1) got_ma = mem_addr;
         if (io_we === 1'b1) begin got_iowe = 1'b1; got_iowd = io_wdata; got_ia = io_addr; end
         if (op_ready === 1'b0) got_busy = 1'b1;
         if (op_done === 1'b1) break;
         @(posedge ref_clk);
      end
      if (op_done !== 1'b1) begin
         fails++;
         $display("ERROR op_done expected 1 seen %b", op_done);
         stop_test();
      end
      chk("cycles", 16'(exp_n), 16'(ncyc));
      chk("busy", 16'(exp_n == 2), {15'h0, got_busy});
      chk("pc", exp_pc, pc);
      chk("status", {8'h00, exp_sr}, {8'h00, status_register});
   endtask : run_op

   task automatic flag_ops;
      cbo_op_e fop [8] = '{CBO_OP_SET_CARRY, CBO_OP_CLEAR_CARRY, CBO_OP_SET_SIGN_FLAG,
         CBO_OP_CLEAR_SIGN_FLAG, CBO_OP_SET_OVERFLOW, CBO_OP_CLEAR_OVERFLOW,
         CBO_OP_SET_HALF_CARRY, CBO_OP_CLEAR_HALF_CARRY};
      int pos [4] = '{CBO_FLAG_C, CBO_FLAG_S, CBO_FLAG_V, CBO_FLAG_H};
      int i;
      // All sets first, so the first clear must spare three flags still at one
      for (int j = 0; j < 8; j++) begin
         i = (j < 4) ? 2 * j : 2 * (j - 4) + 1;
         exp_sr[pos[i / 2]] = ~i[0];
         exp_pc = exp_pc + 16'h0001;
         run_op(fop[i], 8'h00, 3'h0, 7'h00, 2'h0, 6'h00, 1);
      end
   endtask : flag_ops

   task automatic branch(input cbo_op_e op, input logic [6:0] k, input logic taken);
      exp_pc = taken ? exp_pc + {{9{k[6]}}, k} + 16'h0001 : exp_pc + 16'h0001;
      run_op(op, 8'h00, 3'h0, k, 2'h0, 6'h00, taken ? 2 : 1);
   endtask : branch

   task automatic rotate(input cbo_op_e op, input logic [7:0] rd);
      logic [7:0] res;
      res = (op == CBO_OP_ROTATE_LEFT_CARRY) ? {rd[6:0], exp_sr[CBO_FLAG_C]}
                                             : {exp_sr[CBO_FLAG_C], rd[7:1]};
      exp_sr[CBO_FLAG_C] = (op == CBO_OP_ROTATE_LEFT_CARRY) ? rd[7] : rd[0];
      exp_sr[CBO_FLAG_Z] = (res == 8'h00);
      exp_sr[CBO_FLAG_N] = res[7];
      exp_sr[CBO_FLAG_V] = res[7] ^ exp_sr[CBO_FLAG_C];
      exp_pc = exp_pc + 16'h0001;
      run_op(op, rd, 3'h0, 7'h00, 2'h0, 6'h00, 1);
      chk("rotate data", {8'h01, res}, {7'h00, got_we, got_wd});
      chk("rotate reg", 16'h0003, {11'h000, got_wa});
   endtask : rotate

   task automatic io_bit(input cbo_op_e op, input logic [2:0] b);
      io_exp[b] = (op == CBO_OP_SET_IO_BIT);
      exp_pc = exp_pc + 16'h0002;
      run_op(op, 8'h00, b, 7'h00, 2'h0, 6'h00, 2);
      chk("io write", {8'h01, io_exp}, {7'h00, got_iowe, got_iowd});
      chk("io addr", 16'h0005, {10'h000, got_ia});
   endtask : io_bit

   task automatic load(input cbo_op_e op, input logic [1:0] ps, input logic [5:0] q,
                       input logic [15:0] addr, input logic [15:0] ptr_new);
      exp_pc = exp_pc + 16'h0002;
      run_op(op, 8'h00, 3'h0, 7'h00, ps, q, 2);
      chk("load addr", addr, got_ma);
      chk("load reg", 16'h0003, {11'h000, got_wa});
      chk("load data", {8'h01, i_cbo_mem_model.mem_val(addr)}, {7'h00, got_we, got_wd});
      chk("pointer", ptr_new, (ps == 2'h0) ? ptr_x : (ps == 2'h1) ? ptr_y : ptr_z);
   endtask : load

   initial begin
      fails = 0; cmp_count = 0; exp_pc = 16'h0000; exp_sr = 8'h00;
      rst_n = 1'b0; op_valid = 1'b0; op_code = CBO_OP_SET_CARRY; op_reg = 5'h00;
      op_bit = 3'h0; op_offset = 7'h00; op_io_addr = 6'h05; op_ptr_sel = 2'h0;
      op_disp = 6'h00; reg_rdata = 8'h00;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk("reset pc", CBO_PC_RST, pc);
      chk("reset status", {8'h00, CBO_STATUS_RST}, {8'h00, status_register});
      chk("reset pointers", 16'h0000, ptr_x | ptr_y | ptr_z);
      chk("reset ready", 16'h0001, {15'h0, op_ready});
      flag_ops();
      branch(CBO_OP_BRANCH_OVERFLOW_SET, 7'h7D, 1'b0);
      branch(CBO_OP_BRANCH_OVERFLOW_CLEAR, 7'h7D, 1'b1);
      exp_sr[CBO_FLAG_V] = 1'b1;
      exp_pc = exp_pc + 16'h0001;
      run_op(CBO_OP_SET_OVERFLOW, 8'h00, 3'h0, 7'h00, 2'h0, 6'h00, 1);
      branch(CBO_OP_BRANCH_OVERFLOW_SET, 7'h05, 1'b1);
      branch(CBO_OP_BRANCH_OVERFLOW_CLEAR, 7'h05, 1'b0);
      branch(CBO_OP_BRANCH_IRQ_ENABLED, 7'h3F, 1'b0);
      branch(CBO_OP_BRANCH_IRQ_DISABLED, 7'h3F, 1'b1);
      rotate(CBO_OP_ROTATE_LEFT_CARRY, 8'h80);
      rotate(CBO_OP_ROTATE_RIGHT_CARRY, 8'h01);
      rotate(CBO_OP_ROTATE_LEFT_CARRY, 8'h41);
      exp_sr[CBO_FLAG_T] = 1'b1;
      exp_pc = exp_pc + 16'h0001;
      run_op(CBO_OP_BIT_STORE_TO_TRANSFER, 8'h08, 3'h3, 7'h00, 2'h0, 6'h00, 1);
      chk("store no write", 16'h0000, {15'h0, got_we});
      exp_pc = exp_pc + 16'h0001;
      run_op(CBO_OP_BIT_LOAD_FROM_TRANSFER, 8'hF0, 3'h0, 7'h00, 2'h0, 6'h00, 1);
      chk("bit load", 16'h01F1, {7'h00, got_we, got_wd});
      io_exp = 8'h05 ^ 8'hC3;
      io_bit(CBO_OP_SET_IO_BIT, 3'h0);
      io_bit(CBO_OP_CLEAR_IO_BIT, 3'h7);
      // The write pulse lands in the model only at the following edge
      @(posedge ref_clk);
      #1;
      chk("io cell", {8'h00, io_exp}, {8'h00, i_cbo_mem_model.io_mem[5]});
      load(CBO_OP_LOAD_POST_INC, 2'h0, 6'h00, 16'h0000, 16'h0001);
      load(CBO_OP_LOAD_POST_INC, 2'h0, 6'h00, 16'h0001, 16'h0002);
      load(CBO_OP_LOAD_PRE_DEC, 2'h1, 6'h00, 16'hFFFF, 16'hFFFF);
      load(CBO_OP_LOAD_DISP, 2'h2, 6'h3F, 16'h003F, 16'h0000);
      load(CBO_OP_LOAD_PRE_DEC, 2'h3, 6'h00, 16'hFFFF, 16'hFFFF);
      load(CBO_OP_LOAD_DISP, 2'h2, 6'h01, 16'h0000, 16'hFFFF);
      stop_test();
   end
endmodule : tb
